// ---- include/boot_parser_pkg.sv ----
package boot_parser_pkg;

	// ************************************************************
	// Stream and word geometry.
	// ************************************************************
	localparam int WORD_W  = 48;     // Width of one boot stream word.
	localparam int TAG_W   = 16;     // Width of the block tag field.
	localparam int CNT_W   = 16;     // Width of the word count field.
	localparam int ADDR_W  = 32;     // Width of the start address field.
	localparam int ADDR_LO = 16;     // Lowest bit of the start address field.

	// ************************************************************
	// Block tag codes.
	// ************************************************************
	localparam logic [15:0] TAG_FINAL     = 16'h0000; // Final initialization.
	localparam logic [15:0] TAG_ZERO_DM16 = 16'h0001; // Zero fill, data memory 16.
	localparam logic [15:0] TAG_ZERO_DM32 = 16'h0002; // Zero fill, data memory 32.
	localparam logic [15:0] TAG_ZERO_DM40 = 16'h0003; // Zero fill, data memory 40.
	localparam logic [15:0] TAG_INIT_DM16 = 16'h0004; // Body, data memory 16.
	localparam logic [15:0] TAG_INIT_DM32 = 16'h0005; // Body, data memory 32.
	localparam logic [15:0] TAG_ZERO_PM16 = 16'h0007; // Zero fill, program memory 16.
	localparam logic [15:0] TAG_ZERO_PM32 = 16'h0008; // Zero fill, program memory 32.
	localparam logic [15:0] TAG_ZERO_PM40 = 16'h0009; // Zero fill, program memory 40.
	localparam logic [15:0] TAG_ZERO_PM48 = 16'h000A; // Zero fill, program memory 48.
	localparam logic [15:0] TAG_INIT_PM16 = 16'h000B; // Body, program memory 16.
	localparam logic [15:0] TAG_INIT_PM32 = 16'h000C; // Body, program memory 32.
	localparam logic [15:0] TAG_INIT_PM48 = 16'h000E; // Body, program memory 48.
	localparam logic [15:0] TAG_ZERO_DM64 = 16'h000F; // Zero fill, data memory 64.
	localparam logic [15:0] TAG_INIT_DM64 = 16'h0010; // Body, data memory 64.
	localparam logic [15:0] TAG_ZERO_PM64 = 16'h0011; // Zero fill, program memory 64.
	localparam logic [15:0] TAG_INIT_PM64 = 16'h0012; // Body, program memory 64.

	// ************************************************************
	// Register map over APB (byte addresses).
	// ************************************************************
	localparam logic [7:0] OFS_CONTROL = 8'h00; // Boot mode and vector select.
	localparam logic [7:0] OFS_STATUS  = 8'h04; // Parser state and flags.
	localparam logic [7:0] OFS_HOLD_LO = 8'h08; // Held instruction bits 31..0.
	localparam logic [7:0] OFS_HOLD_HI = 8'h0C; // Held instruction bits 47..32.
	localparam logic [7:0] OFS_BLOCKS  = 8'h10; // Count of accepted blocks.

	// Control register bit positions.
	localparam int CTL_VEC_BIT   = 0; // Vector table select bit.
	localparam int CTL_MODE_LO   = 1; // Boot mode field low bit.
	localparam int CTL_PORT_BIT  = 3; // Port enable, external path.
	localparam int CTL_LINK_BIT  = 4; // Port enable, link path.

	// Reset and fixed values.
	localparam logic [31:0] CONTROL_RST   = 32'h0000_0000; // Control after reset.
	localparam logic [31:0] ZERO32        = 32'h0000_0000; // Plain zero word.
	localparam logic [47:0] ZERO48        = 48'h0000_0000_0000; // Zero fill data.
	localparam logic [15:0] CNT_ONE       = 16'h0001; // Count step.
	localparam logic [15:0] CNT_ZERO      = 16'h0000; // Count empty.
	localparam logic [31:0] ADDR_ONE      = 32'h0000_0001; // Address step.
	localparam logic [31:0] RESET_VEC_RUN = 32'h0004_0004; // Second reset vector word.
	localparam int          SYNC_W        = 2; // Synchroniser depth.

	// Boot mode encodings.
	typedef enum logic [1:0] {
		MODE_NOBOOT = 2'b00,
		MODE_PROM   = 2'b01,
		MODE_HOST   = 2'b10,
		MODE_LINK   = 2'b11
	} boot_mode_t;

	// Parser states.
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_HDR0  = 3'b001,
		ST_HDR1  = 3'b010,
		ST_BODY  = 3'b011,
		ST_ZERO  = 3'b100,
		ST_FINAL = 3'b101,
		ST_DONE  = 3'b110
	} parse_state_t;

	// One memory write toward the target memory.
	typedef struct packed {
		logic        valid;   // Write strobe.
		logic        pmSpace; // High for program memory, low for data memory.
		logic [31:0] addr;    // Word address.
		logic [47:0] data;    // Word to store.
	} mem_write_t;

	// Incoming stream word from the boot port.
	typedef struct packed {
		logic        valid; // Word present.
		logic [47:0] data;  // Word value.
	} stream_word_t;

endpackage

// ---- verilog/boot_block_stream_parser.sv ----
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
// Operation
// - first header word tag in low sixteen bits
// - second word holds address and count
// - zero blocks carry no body words
// - body words written from start address
// - zero blocks filled with zeros internally
// - sixteen bit tag decoded exactly
// - data memory tag codes decoded
// - program memory tag codes decoded
// - tag zero marks final initialization
// - one further word held as instruction
// - final init restores configuration and ports
// - boot port vector holds return instruction
// - run starts at second reset vector
// - port enabled before headers are read
// - external boot forces internal vector table
// - no boot mode uses select bit
module boot_block_stream_parser
	import boot_parser_pkg::*;
(
	input  wire logic         mclk,          // Processor clock, 250 MHz.
	input  wire logic         rst_b,         // Asynchronous reset, active low.
	input  wire logic         psel,          // APB select.
	input  wire logic         penable,       // APB access phase.
	input  wire logic         pwrite,        // APB direction, high for write.
	input  wire logic [7:0]   paddr,         // APB byte address.
	input  wire logic [31:0]  pwdata,        // APB write data.
	output logic      [31:0]  prdata,        // APB read data.
	output logic              pready,        // APB ready.
	output logic              pslverr,       // APB error for unmapped address.
	input  wire stream_word_t streamIn,      // Word offered by the boot port.
	output logic              streamReady,   // Parser takes the offered word.
	input  wire logic         bootStart,     // Pin that starts booting.
	output mem_write_t        memWrite,      // Memory write toward target memory.
	output logic [47:0]       wideHoldingRegister,  // Held final instruction.
	output logic              internalVectorTableSelect, // High for internal table.
	output logic              returnFromInterruptInstr,  // Vector must hold the return.
	output logic              restoreDefaults,  // Pulse: restore config and port control.
	output logic              serviceInterrupts, // Pulse: clear pending interrupts.
	output logic              bootDone,      // Boot complete, level.
	output logic [31:0]       runAddress     // Address where execution resumes.
);

	// ************************************************************
	// Tag decoding.
	// ************************************************************

	// Returns high for a tag that names a zero-fill block.
	function automatic logic isZeroTag(input logic [15:0] tag);
		isZeroTag = (tag == TAG_ZERO_DM16) || (tag == TAG_ZERO_DM32) ||
			(tag == TAG_ZERO_DM40) || (tag == TAG_ZERO_DM64) ||
			(tag == TAG_ZERO_PM16) || (tag == TAG_ZERO_PM32) ||
			(tag == TAG_ZERO_PM40) || (tag == TAG_ZERO_PM48) ||
			(tag == TAG_ZERO_PM64);
	endfunction

	// Returns high for a tag that names a block with a body.
	function automatic logic isInitTag(input logic [15:0] tag);
		isInitTag = (tag == TAG_INIT_DM16) || (tag == TAG_INIT_DM32) ||
			(tag == TAG_INIT_DM64) || (tag == TAG_INIT_PM16) ||
			(tag == TAG_INIT_PM32) || (tag == TAG_INIT_PM48) ||
			(tag == TAG_INIT_PM64);
	endfunction

	// Returns high for a program memory tag.
	function automatic logic isPmTag(input logic [15:0] tag);
		isPmTag = (tag == TAG_ZERO_PM16) || (tag == TAG_ZERO_PM32) ||
			(tag == TAG_ZERO_PM40) || (tag == TAG_ZERO_PM48) ||
			(tag == TAG_ZERO_PM64) || (tag == TAG_INIT_PM16) ||
			(tag == TAG_INIT_PM32) || (tag == TAG_INIT_PM48) ||
			(tag == TAG_INIT_PM64);
	endfunction

	// ************************************************************
	// State and storage.
	// ************************************************************
	parse_state_t state;        // Parser state.
	logic [31:0]  control;      // Software control register.
	logic [15:0]  curTag;       // Tag of the block in progress.
	logic [31:0]  curAddr;      // Next memory address.
	logic [15:0]  remaining;    // Words left in the block.
	logic [31:0]  blockCount;   // Blocks accepted so far.
	logic         badTag;       // Sticky flag: an unknown tag was seen.
	logic [SYNC_W-1:0] startSync; // Start pin synchroniser.
	logic         startSeen;    // Start seen after synchronising.

	boot_mode_t   bootMode;     // Boot mode field of control.
	logic         portEnabled;  // Active boot port enable.
	logic         takeWord;     // A stream word is consumed this cycle.
	logic         apbWrite;     // APB write completes this cycle.
	logic [15:0]  hdrTag;       // Tag field of the offered word.

	assign bootMode = boot_mode_t'(control[CTL_MODE_LO +: 2]);
	assign hdrTag   = streamIn.data[TAG_W-1:0];

	assign portEnabled = (bootMode == MODE_LINK) ? control[CTL_LINK_BIT] :
		control[CTL_PORT_BIT];

	// Words are only taken in states that read the stream; the zero fill
	// stalls the port so no word is swallowed while zeros are written.
	// no body for zero
	assign streamReady = portEnabled && ((state == ST_HDR0) ||
		(state == ST_HDR1) || (state == ST_BODY) || (state == ST_FINAL));
	assign takeWord = streamReady && streamIn.valid;

	// APB answers with no wait states.
	assign pready  = 1'b1;
	assign apbWrite = psel && penable && pwrite;

	// ************************************************************
	// Start pin synchroniser.
	// ************************************************************

	// The first stage is read only by the second stage.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			startSync <= '0;
		end else begin
			startSync <= {startSync[0], bootStart};
		end
	end

	assign startSeen = startSync[SYNC_W-1];

	// ************************************************************
	// Control register.
	// ************************************************************

	// Final initialization puts the control register back to its defaults,
	// which also closes the port enables.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			control <= CONTROL_RST;
		end else if ((state == ST_FINAL) && takeWord) begin
			control <= CONTROL_RST;
		end else if (apbWrite && (paddr == OFS_CONTROL)) begin
			control <= pwdata;
		end
	end

	// ************************************************************
	// Parser state machine.
	// ************************************************************

	// Walks header, body or fill, and the final section.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					// A parse never starts in no-boot mode.
					if (startSeen && (bootMode != MODE_NOBOOT)) begin
						state <= ST_HDR0;
					end
				end
				ST_HDR0: begin
					if (takeWord) begin
						if (hdrTag == TAG_FINAL) begin
							state <= ST_FINAL;
						end else begin
							state <= ST_HDR1;
						end
					end
				end
				ST_HDR1: begin
					if (takeWord) begin
						if (streamIn.data[CNT_W-1:0] == CNT_ZERO) begin
							state <= ST_HDR0;
						end else if (isZeroTag(curTag)) begin
							state <= ST_ZERO;
						end else if (isInitTag(curTag)) begin
							state <= ST_BODY;
						end else begin
							// Unknown tags are skipped as empty blocks.
							state <= ST_HDR0;
						end
					end
				end
				ST_BODY: begin
					if (takeWord && (remaining == CNT_ONE)) begin
						state <= ST_HDR0;
					end
				end
				ST_ZERO: begin
					if (remaining == CNT_ONE) begin
						state <= ST_HDR0;
					end
				end
				ST_FINAL: begin
					if (takeWord) begin
						state <= ST_DONE;
					end
				end
				ST_DONE: begin
					state <= ST_DONE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// Header fields, address and count.
	// ************************************************************

	// Latches the tag and walks address and count through the block.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			curTag    <= CNT_ZERO;
			curAddr   <= ZERO32;
			remaining <= CNT_ZERO;
		end else if ((state == ST_HDR0) && takeWord) begin
			curTag <= hdrTag;
		end else if ((state == ST_HDR1) && takeWord) begin
			curAddr   <= streamIn.data[ADDR_LO +: ADDR_W];
			remaining <= streamIn.data[CNT_W-1:0];
		end else if (((state == ST_BODY) && takeWord) || (state == ST_ZERO)) begin
			curAddr   <= curAddr + ADDR_ONE;
			remaining <= remaining - CNT_ONE;
		end
	end

	// ************************************************************
	// Memory write port.
	// ************************************************************

	// Registered so the write carries data straight from flip-flops.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			memWrite <= '0;
		end else begin
			memWrite.valid   <= 1'b0;
			memWrite.pmSpace <= isPmTag(curTag);
			memWrite.addr    <= curAddr;
			if ((state == ST_BODY) && takeWord) begin
				memWrite.valid <= 1'b1;
				memWrite.data  <= streamIn.data;
			end else if (state == ST_ZERO) begin
				memWrite.valid <= 1'b1;
				memWrite.data  <= ZERO48;
			end
		end
	end

	// ************************************************************
	// Final section and completion.
	// ************************************************************

	// Captures the trailing instruction and pulses the restore actions.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wideHoldingRegister <= ZERO48;
			restoreDefaults     <= 1'b0;
			serviceInterrupts   <= 1'b0;
			bootDone            <= 1'b0;
			runAddress          <= ZERO32;
		end else begin
			restoreDefaults   <= 1'b0;
			serviceInterrupts <= 1'b0;
			if ((state == ST_FINAL) && takeWord) begin
				wideHoldingRegister <= streamIn.data;
				restoreDefaults     <= 1'b1;
				serviceInterrupts   <= 1'b1;
				bootDone            <= 1'b1;
				runAddress          <= RESET_VEC_RUN;
			end
		end
	end

	assign returnFromInterruptInstr = (state != ST_IDLE) && (state != ST_DONE);

	assign internalVectorTableSelect = (bootMode != MODE_NOBOOT) ? 1'b1 :
		control[CTL_VEC_BIT];

	// ************************************************************
	// Block counter and error flag.
	// ************************************************************

	// Counts block headers other than the final one and flags tags outside the known set.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			blockCount <= ZERO32;
			badTag     <= 1'b0;
		end else if ((state == ST_HDR1) && takeWord) begin
			blockCount <= blockCount + ADDR_ONE;
			if (!isZeroTag(curTag) && !isInitTag(curTag)) begin
				badTag <= 1'b1;
			end
		end
	end

	// ************************************************************
	// APB read decode.
	// ************************************************************

	// Read data comes straight from the decode; unmapped reads return zero
	// with an error.
	always_comb begin
		prdata  = ZERO32;
		pslverr = 1'b0;
		if (paddr == OFS_CONTROL) begin
			prdata = control;
		end else if (paddr == OFS_STATUS) begin
			prdata = {26'h000_0000, badTag, bootDone, 1'b0, state};
		end else if (paddr == OFS_HOLD_LO) begin
			prdata = wideHoldingRegister[31:0];
		end else if (paddr == OFS_HOLD_HI) begin
			prdata = {16'h0000, wideHoldingRegister[47:32]};
		end else if (paddr == OFS_BLOCKS) begin
			prdata = blockCount;
		end else begin
			pslverr = psel && penable;
		end
	end

endmodule // boot_block_stream_parser

// ---- tb/boot_block_stream_parser_sva.sv ----
`timescale 1ns/1ps
// ************************************************************
// Port checks for the boot stream parser.
// ************************************************************
module boot_block_stream_parser_sva
	import boot_parser_pkg::*;
(
	input wire logic         mclk,                      // Clock.
	input wire logic         rst_b,                     // Reset, active low.
	input wire logic         psel,                      // APB select.
	input wire logic         penable,                   // APB access phase.
	input wire logic         pwrite,                    // APB direction.
	input wire logic [7:0]   paddr,                     // APB address.
	input wire logic [31:0]  pwdata,                    // APB write data.
	input wire logic [31:0]  prdata,                    // APB read data.
	input wire logic         pready,                    // APB ready.
	input wire logic         pslverr,                   // APB error.
	input wire stream_word_t streamIn,                  // Offered word.
	input wire logic         streamReady,               // Word taken.
	input wire logic         bootStart,                 // Boot pin.
	input wire mem_write_t   memWrite,                  // Memory write.
	input wire logic [47:0]  wideHoldingRegister,       // Held instruction.
	input wire logic         internalVectorTableSelect, // Table select.
	input wire logic         returnFromInterruptInstr,  // Parsing level.
	input wire logic         restoreDefaults,           // Restore pulse.
	input wire logic         serviceInterrupts,         // Service pulse.
	input wire logic         bootDone,                  // Done level.
	input wire logic [31:0]  runAddress                 // Resume address.
);
	// One clock domain, so clocking and reset are given once.
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	a_closed_after_done: assert property (bootDone |-> !streamReady)
		else $error("Stream word accepted after boot done.");
	a_done_sticky: assert property (bootDone |=> bootDone)
		else $error("Boot done dropped.");
	a_run_vector: assert property ($rose(bootDone) |-> runAddress == 32'h0004_0004)
		else $error("Run address wrong at boot done.");
	a_final_pulses: assert property ($rose(bootDone) |->
		restoreDefaults && serviceInterrupts ##1 !restoreDefaults && !serviceInterrupts)
		else $error("Final pulses wrong.");
	a_final_hold: assert property ($rose(bootDone) |->
		wideHoldingRegister == $past(streamIn.data))
		else $error("Held instruction differs from last word.");
	a_booted_internal: assert property (returnFromInterruptInstr |-> internalVectorTableSelect)
		else $error("Vector table not internal while booting.");
	a_return_parse: assert property (bootDone |-> !returnFromInterruptInstr)
		else $error("Return vector still flagged after done.");
	a_body_copy: assert property (memWrite.valid && memWrite.data != 48'h0 |->
		$past(streamIn.valid && streamReady) && memWrite.data == $past(streamIn.data))
		else $error("Body write not a copy of the taken word.");
	a_idle_refuse: assert property (!returnFromInterruptInstr |-> !streamReady)
		else $error("Word taken while not parsing.");
endmodule // boot_block_stream_parser_sva

bind boot_block_stream_parser boot_block_stream_parser_sva u_sva (.mclk(mclk), .rst_b(rst_b),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .streamIn(streamIn),
	.streamReady(streamReady), .bootStart(bootStart), .memWrite(memWrite),
	.wideHoldingRegister(wideHoldingRegister), .internalVectorTableSelect(internalVectorTableSelect),
	.returnFromInterruptInstr(returnFromInterruptInstr), .restoreDefaults(restoreDefaults),
	.serviceInterrupts(serviceInterrupts), .bootDone(bootDone), .runAddress(runAddress));

// ---- tb/boot_source_model.sv ----
`timescale 1ns/1ps
// ************************************************************
// Boot source that offers queued words to the parser.
// ************************************************************
module boot_source_model
	import boot_parser_pkg::*;
(
	input  wire logic   mclk,        // Clock.
	input  wire logic   rst_b,       // Reset, active low.
	input  wire logic   streamReady, // Parser takes the word.
	input  wire logic   stall,       // High: offer only every other cycle.
	output stream_word_t streamIn    // Word offered to the parser.
);
	logic [47:0] words [$]; // Words still to send.
	logic        gap;       // Toggles to pace a slow source.

	// Queue one word; call only away from a clock edge.
	task automatic push(input logic [47:0] w);
		words.push_back(w);
	endtask

	// A word stands until taken; idle data changes so stale values never match.
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			streamIn <= '0;
			gap <= 1'b0;
			// A reset drops whatever was still queued, so no stale block follows it.
			words.delete();
		end else begin
			gap <= ~gap;
			if (streamIn.valid && streamReady !== 1'b1) begin
				streamIn <= streamIn;
			end else if (words.size() > 0 && !(stall && gap)) begin
				streamIn.valid <= 1'b1;
				streamIn.data <= words.pop_front();
			end else begin
				streamIn.valid <= 1'b0;
				streamIn.data <= ~streamIn.data;
			end
		end
	end
endmodule // boot_source_model

// ---- tb/tb_boot_block_stream_parser.sv ----
`timescale 1ns/1ps
module tb_boot_block_stream_parser;
	import boot_parser_pkg::*;
	logic         mclk, rst_b, psel, penable, pwrite, bootStart, stall, er;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, runAddress, rd;
	logic         pready, pslverr, streamReady, ivts, return_from_interrupt_instr, restoreDefaults, serviceInterrupts;
	logic         bootDone;
	logic [47:0]  wideHoldingRegister;
	stream_word_t streamIn;
	mem_write_t   memWrite;
	logic [80:0]  gotQ [$];
	logic [80:0]  expQ [$];
	int           err_total, check_count;
	// Tag table: dm zero, dm init, pm zero, pm init.
	localparam logic [15:0] TAGS [16] = '{16'h0001, 16'h0002, 16'h0003, 16'h000F, 16'h0004,
		16'h0005, 16'h0010, 16'h0007, 16'h0008, 16'h0009, 16'h000A, 16'h0011, 16'h000B,
		16'h000C, 16'h000E, 16'h0012};

	boot_block_stream_parser u_boot_block_stream_parser (.mclk(mclk), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .streamIn(streamIn),
		.streamReady(streamReady), .bootStart(bootStart), .memWrite(memWrite),
		.wideHoldingRegister(wideHoldingRegister), .internalVectorTableSelect(ivts),
		.returnFromInterruptInstr(return_from_interrupt_instr), .restoreDefaults(restoreDefaults),
		.serviceInterrupts(serviceInterrupts), .bootDone(bootDone), .runAddress(runAddress));
	boot_source_model u_boot_source_model (.mclk(mclk), .rst_b(rst_b),
		.streamReady(streamReady), .stall(stall), .streamIn(streamIn));

	// Clock at 250 MHz.
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// Record every memory write the parser makes.
	always @(posedge mclk) begin
		if (memWrite.valid === 1'b1) gotQ.push_back({memWrite.pmSpace, memWrite.addr, memWrite.data});
	end

	task automatic chk(input logic [80:0] got, input logic [80:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One APB transfer; waits for pready under a bound, then settles.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		// Answers are read while they stand, before the edge that ends the access.
		do begin
			@(negedge mclk);
			rd = prdata;
			er = pslverr;
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			end_sim();
		end
		@(posedge mclk);
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	// Reset value and an unmapped place.
	task automatic s_regs();
		apb(1'b0, OFS_CONTROL, 32'h0);
		chk(rd, 32'h0000_0000);
		apb(1'b1, 8'h14, 32'hFFFF_FFFF);
		apb(1'b0, 8'h14, 32'h0);
		chk({er, rd}, {1'b1, 32'h0});
		apb(1'b0, OFS_CONTROL, 32'h0);
		chk(rd, 32'h0000_0000);
	endtask

	// Vector table placement in every mode, both select values.
	task automatic s_vector();
		for (int m = 0; m < 4; m++) begin
			for (int v = 0; v < 2; v++) begin
				apb(1'b1, OFS_CONTROL, 32'(m * 2 + v));
				chk(ivts, (m == 0) ? v[0] : 1'b1);
			end
		end
		apb(1'b1, OFS_CONTROL, 32'h0);
	endtask

	// Every tag, a bad tag, then final section, with the source slowing midway.
	task automatic s_boot();
		logic [47:0] w;
		logic [31:0] ad;
		logic        zero;
		int          n;
		for (int i = 0; i < 16; i++) begin
			zero = (i < 4) || (i >= 7 && i < 12);
			ad = 32'h0002_0000 + 32'(i * 8);
			u_boot_source_model.push({32'hDEAD_BEEF, TAGS[i]});
			u_boot_source_model.push({ad, 16'h0002});
			for (int j = 0; j < 2; j++) begin
				w = {16'hA5A5, 16'(i), 16'(j + 1)};
				if (!zero) u_boot_source_model.push(w);
				expQ.push_back({i >= 7, ad + 32'(j), zero ? 48'h0 : w});
			end
		end
		u_boot_source_model.push({32'h0, 16'h0006});
		u_boot_source_model.push({32'h0003_0000, 16'h0000});
		u_boot_source_model.push({32'h1234_5678, 16'h0000});
		u_boot_source_model.push(48'h0F0E_0D0C_0B0A);
		apb(1'b1, OFS_CONTROL, 32'h0000_000A);
		@(posedge mclk);
		bootStart <= 1'b1;
		repeat (40) @(posedge mclk);
		stall <= 1'b1;
		n = 0;
		while (bootDone !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 3000) begin
			err_total++;
			end_sim();
		end
		#1;
		chk(runAddress, 32'h0004_0004);
		chk(wideHoldingRegister, 48'h0F0E_0D0C_0B0A);
		chk(81'(gotQ.size()), 81'(expQ.size()));
		for (int k = 0; k < expQ.size() && k < gotQ.size(); k++) chk(gotQ[k], expQ[k]);
		chk(ivts, 1'b0);
		apb(1'b0, OFS_CONTROL, 32'h0);
		chk(rd, 32'h0000_0000);
		apb(1'b0, OFS_HOLD_LO, 32'h0);
		chk(rd, 32'h0D0C_0B0A);
		apb(1'b0, OFS_HOLD_HI, 32'h0);
		chk(rd, 32'h0000_0F0E);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, {26'h000_0000, 1'b1, 1'b1, 1'b0, ST_DONE});
	endtask

	// A block offered after the final section must stay untaken.
	task automatic s_after();
		int n;
		n = gotQ.size();
		u_boot_source_model.push({32'h0, 16'h0004});
		u_boot_source_model.push({32'h0005_0000, 16'h0001});
		u_boot_source_model.push(48'h0000_0000_0001);
		repeat (20) @(posedge mclk);
		#1;
		chk(81'(gotQ.size()), 81'(n));
		chk(streamIn.valid, 1'b1);
	endtask

	// Mid-run reset; a booted parser with its port closed must take nothing.
	task automatic s_port();
		int n;
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		apb(1'b0, OFS_CONTROL, 32'h0);
		chk(rd, 32'h0000_0000);
		apb(1'b1, OFS_CONTROL, 32'h0000_0002);
		n = gotQ.size();
		u_boot_source_model.push({32'h0, TAG_INIT_DM16});
		u_boot_source_model.push({32'h0005_0000, 16'h0001});
		u_boot_source_model.push(48'h0000_0000_0001);
		repeat (10) @(posedge mclk);
		#1;
		chk({return_from_interrupt_instr, streamReady, streamIn.valid}, 3'b101);
		apb(1'b1, OFS_CONTROL, 32'h0000_000A);
		repeat (10) @(posedge mclk);
		#1;
		chk(81'(gotQ.size()), 81'(n + 1));
		chk(gotQ[gotQ.size() - 1], {1'b0, 32'h0005_0000, 48'h0000_0000_0001});
	endtask

	// Main sequence.
	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		bootStart = 1'b0;
		stall = 1'b0;
		err_total = 0;
		check_count = 0;
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		s_regs();
		s_vector();
		s_boot();
		s_after();
		s_port();
		end_sim();
	end
endmodule // tb_boot_block_stream_parser
